// ==== verilog/irq_flag_ctrl.sv ====
/*
  Interrupt control register two and flag registers zero and one,
  reached over APB, with external pin edge detection.
  Assumes request inputs are pclk-synchronous pulses or levels.
*/
// The APB register port and the address map were decided locally.
// Operation
// R1 - Vector select bit 15 picks alternate table when 1, standard when 0.
// R2 - Bit 14 reads 1 while timed interrupt disable is active.
// R3 - Polarity bit 1 selects falling edge, 0 rising, for inputs 0-2.
// R4 - Control bits 13 to 3 read zero.
// R5 - Flags zero: I2C master 14, I2C slave 13, memory 12, converter 11.
// R6 - Flags zero: serial tx 10, serial rx 9, SPI 8.
// R7 - Flags zero: timer three 7, timer two 6, timer one 3.
// R8 - Flags zero: compare two 5, compare one 2, capture one 1.
// R9 - Flags zero bit 0 is external 0; bits 15 and 4 read zero.
// R10 - Flags one: comparators three, two, one at bits 15, 14, 13.
// R11 - Flags one bit 11 is change notification.
// R12 - Flags one: pulse generators four to one at bits 6 to 3.
// R13 - Flags one bit 2 is special event match.
// R14 - Flags one bit 1 is external 2, bit 0 external 1.
// R15 - Flags one bits 12 and 10 to 7 read zero.
// R16 - Implemented flags show requests and are software read/write.
// R17 - All implemented bits are zero after reset.
// R18 - External inputs respond to edges, never to levels.
// R19 - Flags stay set until cleared; a new request beats a clear.
// R20 - Set flags drive their requests continuously.
`timescale 1ns/1ps
`include "irq_flag_consts.svh"

module irq_flag_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  ext_irq_pin,
  input  wire logic [15:0] flags0_src,
  input  wire logic [15:0] flags1_src,
  input  wire logic        timed_irq_disable_active,
  output logic             alt_vector_table_select,
  output logic [2:0]       ext_irq_edge_polarity,
  output logic [15:0]      flags0_irq,
  output logic [15:0]      flags1_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  irq_flag_pkg::half_t    ctrl_reg;
  irq_flag_pkg::half_t    ctrl_next;
  irq_flag_pkg::half_t    flags0_reg;
  irq_flag_pkg::half_t    flags0_next;
  irq_flag_pkg::half_t    flags1_reg;
  irq_flag_pkg::half_t    flags1_next;
  logic [31:0]            prdata_reg;
  logic [31:0]            prdata_next;
  irq_flag_pkg::half_t    set0;
  irq_flag_pkg::half_t    set1;
  irq_flag_pkg::half_t    ctrl_view;
  irq_flag_pkg::reg_sel_e sel;
  logic                   setup_phase;
  logic                   access_phase;
  logic                   wr_ctrl;
  logic                   wr_flags0;
  logic                   wr_flags1;

  ext_edge_if edge_bus ();

  ext_edge_detect u_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .ext_irq_pin (ext_irq_pin),
    .edge_bus    (edge_bus.detect)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign sel =
    (paddr == `CTRL_TWO_ADDR)   ? irq_flag_pkg::SEL_CTRL   :
    (paddr == `FLAGS_ZERO_ADDR) ? irq_flag_pkg::SEL_FLAGS0 :
    (paddr == `FLAGS_ONE_ADDR)  ? irq_flag_pkg::SEL_FLAGS1 :
                                  irq_flag_pkg::SEL_NONE;
  assign wr_ctrl   = access_phase & pwrite &
                     (sel == irq_flag_pkg::SEL_CTRL);
  assign wr_flags0 = access_phase & pwrite &
                     (sel == irq_flag_pkg::SEL_FLAGS0);
  assign wr_flags1 = access_phase & pwrite &
                     (sel == irq_flag_pkg::SEL_FLAGS1);
  assign pready  = 1'b1;
  assign pslverr = access_phase & (sel == irq_flag_pkg::SEL_NONE);

  // ****************************************************************
  // Control register two
  // ****************************************************************
  // Live status merged over stored bits, reserved field zero
  assign ctrl_view = ctrl_reg |
    {1'b0, timed_irq_disable_active, 14'h0000}; // R2 R4
  assign ctrl_next = wr_ctrl ?
    irq_flag_pkg::lane_write(ctrl_reg, pwdata, pstrb, `CTRL_WR_MASK) :
    ctrl_reg; // R4

  assign alt_vector_table_select = ctrl_reg[`ALT_VEC_BIT]; // R1
  assign ext_irq_edge_polarity =
    ctrl_reg[`EXT_POL_LSB +: `EXT_COUNT];
  assign edge_bus.polarity =
    ctrl_reg[`EXT_POL_LSB +: `EXT_COUNT]; // R3

  // ****************************************************************
  // Flag sources
  // ****************************************************************
  assign set0 = {1'b0,              // R9
                 flags0_src[14:11], // R5
                 flags0_src[10:8],  // R6
                 flags0_src[7:6],   // R7
                 flags0_src[5],     // R8
                 1'b0,              // R9
                 flags0_src[3],     // R7
                 flags0_src[2:1],   // R8
                 edge_bus.edge_pulse[0]}; // R9
  assign set1 = {flags1_src[15:13], // R10
                 1'b0,              // R15
                 flags1_src[11],    // R11
                 4'h0,              // R15
                 flags1_src[6:3],   // R12
                 flags1_src[2],     // R13
                 edge_bus.edge_pulse[2],
                 edge_bus.edge_pulse[1]}; // R14

  // Write replaces the flags, any request in the same cycle wins
  assign flags0_next = (wr_flags0 ?
    irq_flag_pkg::lane_write(flags0_reg, pwdata, pstrb,
                             `FLAGS_ZERO_MASK) :
    flags0_reg) | set0; // R16 R19
  assign flags1_next = (wr_flags1 ?
    irq_flag_pkg::lane_write(flags1_reg, pwdata, pstrb,
                             `FLAGS_ONE_MASK) :
    flags1_reg) | set1; // R16 R19

  assign flags0_irq = flags0_reg; // R20
  assign flags1_irq = flags1_reg; // R20

  // ****************************************************************
  // Read data, captured in the setup cycle
  // ****************************************************************
  assign prdata_next =
    !setup_phase                       ? prdata_reg :
    (sel == irq_flag_pkg::SEL_CTRL)   ? {16'h0000, ctrl_view} :
    (sel == irq_flag_pkg::SEL_FLAGS0) ? {16'h0000, flags0_reg} :
    (sel == irq_flag_pkg::SEL_FLAGS1) ? {16'h0000, flags1_reg} :
                                        `BUS_ZERO;
  assign prdata = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `REG_RESET; // R17
      flags0_reg <= `REG_RESET; // R17
      flags1_reg <= `REG_RESET; // R17
      prdata_reg <= `BUS_ZERO;
    end else begin
      ctrl_reg   <= ctrl_next;
      flags0_reg <= flags0_next;
      flags1_reg <= flags1_next;
      prdata_reg <= prdata_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ctrl_read_s;
    setup_phase && !pwrite && sel == irq_flag_pkg::SEL_CTRL ##1
    access_phase;
  endsequence

  sequence flags1_read_s;
    setup_phase && !pwrite && sel == irq_flag_pkg::SEL_FLAGS1 ##1
    access_phase;
  endsequence

  alt_vector_write_a: assert property ( // R1
    wr_ctrl && pstrb[1] |=>
      alt_vector_table_select == $past(pwdata[15]))
    else $error("vector select did not follow write");

  disable_status_read_a: assert property ( // R2
    ctrl_read_s |-> prdata[14] == $past(timed_irq_disable_active))
    else $error("timed disable status misread");

  ctrl_reserved_zero_a: assert property ( // R4
    ctrl_read_s |-> prdata[13:3] == 11'h000)
    else $error("control reserved bits not zero");

  ext_zero_flag_a: assert property ( // R9
    edge_bus.edge_pulse[0] |=> flags0_reg[0])
    else $error("external 0 edge did not set flag");

  flags0_reserved_a: assert property ( // R9
    !flags0_reg[15] && !flags0_reg[4])
    else $error("flags zero reserved bit set");

  flags1_reserved_a: assert property ( // R15
    flags1_reg[12] == 1'b0 && flags1_reg[10:7] == 4'h0)
    else $error("flags one reserved bit set");

  flags1_readback_a: assert property ( // R16
    flags1_read_s |-> prdata[15:0] == $past(flags1_reg))
    else $error("flags one read data wrong");

  set_beats_clear_a: assert property ( // R19
    wr_flags0 && pstrb[1] && !pwdata[11] && flags0_src[11] |=>
      flags0_reg[11])
    else $error("request lost to clearing write");

  flag_sticky_a: assert property ( // R19
    flags1_reg[13] && !wr_flags1 |=> flags1_reg[13])
    else $error("flag dropped without a write");

  pulse_gen_map_a: assert property ( // R12
    flags1_src[6] |=> flags1_irq[6])
    else $error("pulse generator four not mapped to bit 6");

  // ****************************************************************
  // Control, bit mapping and flag clear, set and hold checks
  // ****************************************************************
  disable_not_stored_a: assert property ( // R2
    !ctrl_reg[`TIMED_DIS_BIT])
    else $error("timed disable status stored by a write");

  polarity_write_a: assert property ( // R3
    wr_ctrl && pstrb[0] |=>
      ext_irq_edge_polarity == $past(pwdata[2:0]))
    else $error("edge polarity did not follow write");

  polarity_hold_a: assert property ( // R3
    !wr_ctrl |=> $stable(ext_irq_edge_polarity))
    else $error("edge polarity changed without a write");

  ctrl_store_zero_a: assert property ( // R4
    ctrl_reg[13:3] == 11'h000)
    else $error("control reserved bits stored");

  memory_flag_map_a: assert property ( // R5
    flags0_src[12] |=> flags0_irq[12])
    else $error("memory request not mapped to bit 12");

  serial_rx_map_a: assert property ( // R6
    flags0_src[9] |=> flags0_irq[9])
    else $error("serial receive request not mapped to bit 9");

  timer_one_map_a: assert property ( // R7
    flags0_src[3] |=> flags0_irq[3])
    else $error("timer one request not mapped to bit 3");

  capture_map_a: assert property ( // R8
    flags0_src[1] |=> flags0_irq[1])
    else $error("capture request not mapped to bit 1");

  comparator_map_a: assert property ( // R10
    flags1_src[15] |=> flags1_irq[15])
    else $error("comparator three not mapped to bit 15");

  change_notify_map_a: assert property ( // R11
    flags1_src[11] |=> flags1_irq[11])
    else $error("change notification not mapped to bit 11");

  special_event_map_a: assert property ( // R13
    flags1_src[2] |=> flags1_irq[2])
    else $error("special event not mapped to bit 2");

  ext_two_map_a: assert property ( // R14
    edge_bus.edge_pulse[2] |=> flags1_irq[1])
    else $error("external 2 edge did not set flag");

  ext_one_map_a: assert property ( // R14
    edge_bus.edge_pulse[1] |=> flags1_irq[0])
    else $error("external 1 edge did not set flag");

  flag_clear_a: assert property ( // R16
    wr_flags0 && pstrb[0] && !pwdata[3] && !flags0_src[3] |=>
      !flags0_reg[3])
    else $error("flag not cleared by software write");

  flag_soft_set_a: assert property ( // R16
    wr_flags1 && pstrb[1] && pwdata[14] |=> flags1_reg[14])
    else $error("flag not set by software write");

  flag_hold_a: assert property ( // R19
    flags0_reg[5] && !wr_flags0 |=> flags0_reg[5])
    else $error("flags zero bit dropped without a write");

endmodule

// ==== verilog/irq_flag_consts.svh ====
/*
  Offsets, field positions, masks and reset values of the interrupt
  control and flag registers.
  Assumes a 32-bit APB with one register per aligned word.
*/
`ifndef IRQ_FLAG_CONSTS_SVH
`define IRQ_FLAG_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CTRL_TWO_ADDR     12'h000
`define FLAGS_ZERO_ADDR   12'h004
`define FLAGS_ONE_ADDR    12'h008

// ****************************************************************
// Fields and masks
// ****************************************************************
`define ALT_VEC_BIT       15
`define TIMED_DIS_BIT     14
`define EXT_POL_LSB       0
`define EXT_COUNT         3
`define CTRL_WR_MASK      16'h8007
`define FLAGS_ZERO_MASK   16'h7fef
`define FLAGS_ONE_MASK    16'he87f
`define REG_RESET         16'h0000
`define BUS_ZERO          32'h0000_0000

`endif

// ==== verilog/irq_flag_pkg.sv ====
/*
  Types and the byte-lane write helper shared by the interrupt
  flag block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irq_flag_pkg;

  typedef logic [15:0] half_t;
  typedef logic [2:0]  ext_t;

  typedef enum logic [1:0] {
    SEL_CTRL,
    SEL_FLAGS0,
    SEL_FLAGS1,
    SEL_NONE
  } reg_sel_e;

  // Merge byte lanes of a write into a 16-bit register
  function automatic half_t lane_write(input half_t       old,
                                       input logic [31:0] wd,
                                       input logic [3:0]  strb,
                                       input half_t       mask);
    half_t v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & mask;
  endfunction

endpackage

// ==== verilog/ext_edge_if.sv ====
/*
  Interface between the register block and the external pin edge
  detector: polarity selects go out, edge pulses come back.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps

interface ext_edge_if;
  irq_flag_pkg::ext_t polarity;
  irq_flag_pkg::ext_t edge_pulse;

  modport regs (output polarity, input edge_pulse);
  modport detect (input polarity, output edge_pulse);
endinterface

// ==== verilog/ext_edge_detect.sv ====
/*
  Synchronises the three external interrupt pins and reports one
  pulse per edge of the selected direction.
  Assumes pins are asynchronous to pclk.
*/
`timescale 1ns/1ps

module ext_edge_detect (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [2:0]  ext_irq_pin,
  ext_edge_if.detect       edge_bus
);

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] last_reg;
  logic [2:0] rise;
  logic [2:0] fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      last_reg <= 3'h0;
    end else begin
      meta_reg <= ext_irq_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Transitions only, never levels
  assign rise = sync_reg & ~last_reg; // R18
  assign fall = ~sync_reg & last_reg; // R18
  // Polarity 1 picks the falling edge
  assign edge_bus.edge_pulse =
    (edge_bus.polarity & fall) | (~edge_bus.polarity & rise); // R3

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  edge_fall_a: assert property ( // R3
    edge_bus.polarity[0] && $fell(sync_reg[0]) |-> edge_bus.edge_pulse[0])
    else $error("falling edge missed on input 0");
  edge_rise_a: assert property ( // R3
    !edge_bus.polarity[1] && $rose(sync_reg[1]) |-> edge_bus.edge_pulse[1])
    else $error("rising edge missed on input 1");
  level_quiet_a: assert property ( // R18
    $stable(sync_reg[2]) |-> !edge_bus.edge_pulse[2])
    else $error("request raised without a transition");

endmodule

// ==== tb/irq_source_model.sv ====
/*
  Behavioural model of the request sources and processor core that
  face the interrupt flag block: peripheral requests, pins, status.
  Assumes the bench calls its tasks; all changes follow a rising edge.
*/
`timescale 1ns/1ps

module irq_source_model (
  input  wire logic  pclk,
  output logic [15:0] flags0_src,
  output logic [15:0] flags1_src,
  output logic [2:0]  ext_irq_pin,
  output logic        timed_irq_disable_active
);
  initial begin
    flags0_src = 16'h0000;
    flags1_src = 16'h0000;
    ext_irq_pin = 3'h0;
    timed_irq_disable_active = 1'b0;
  end

  // Request levels held until changed
  task automatic drive_src(input logic [15:0] m0, input logic [15:0] m1);
    @(posedge pclk);
    flags0_src <= m0;
    flags1_src <= m1;
  endtask

  // One-cycle request from each selected source
  task automatic pulse(input logic [15:0] m0, input logic [15:0] m1);
    drive_src(m0, m1);
    drive_src(16'h0000, 16'h0000);
  endtask

  task automatic set_pins(input logic [2:0] v);
    @(posedge pclk);
    ext_irq_pin <= v;
  endtask

  task automatic set_disable(input logic v);
    @(posedge pclk);
    timed_irq_disable_active <= v;
  endtask
endmodule

// ==== tb/tb_irq_flag_ctrl.sv ====
/*
  Self-checking bench for the interrupt control and flag registers.
  Assumes the register offsets and masks of irq_flag_consts.svh.
*/
`timescale 1ns/1ps
`include "irq_flag_consts.svh"

module tb_irq_flag_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        serr, alt_vector_table_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb;
  logic [2:0]  ext_irq_pin, ext_irq_edge_polarity;
  logic [15:0] flags0_src, flags1_src, flags0_irq, flags1_irq;
  logic        timed_irq_disable_active;
  int          err_total, cmp_count;

  irq_flag_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .flags0_src(flags0_src),
    .flags1_src(flags1_src),
    .timed_irq_disable_active(timed_irq_disable_active),
    .alt_vector_table_select(alt_vector_table_select),
    .ext_irq_edge_polarity(ext_irq_edge_polarity),
    .flags0_irq(flags0_irq), .flags1_irq(flags1_irq)
  );

  irq_source_model u_src (
    .pclk(pclk), .flags0_src(flags0_src), .flags1_src(flags1_src),
    .ext_irq_pin(ext_irq_pin),
    .timed_irq_disable_active(timed_irq_disable_active)
  );

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  always #5 pclk = ~pclk;

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rdata, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    u_src.pulse(16'h0800, 16'h8000);
    wr(`CTRL_TWO_ADDR, 32'h0000_8007);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`CTRL_TWO_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0000);
    chk({16'h0000, flags0_irq | flags1_irq}, 32'h0000_0000);
  endtask

  task automatic test_ctrl();
    wr(`CTRL_TWO_ADDR, 32'hffff_ffff);
    rd_chk(`CTRL_TWO_ADDR, 32'h0000_8007);
    chk({31'h0000_0000, alt_vector_table_select}, 32'h0000_0001);
    u_src.set_disable(1'b1);
    rd_chk(`CTRL_TWO_ADDR, 32'h0000_c007);
    u_src.set_disable(1'b0);
    apb(1'b1, `CTRL_TWO_ADDR, 32'h0000_0000, 4'h1);
    rd_chk(`CTRL_TWO_ADDR, 32'h0000_8000);
    chk({31'h0000_0000, alt_vector_table_select}, 32'h0000_0001);
    wr(`CTRL_TWO_ADDR, 32'h0000_0000);
    @(posedge pclk);
    chk({31'h0000_0000, alt_vector_table_select}, 32'h0000_0000);
  endtask

  task automatic test_flags();
    u_src.pulse(16'hffff, 16'hffff);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_7fee);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_e87c);
    chk({16'h0000, flags0_irq}, 32'h0000_7fee);
    chk({16'h0000, flags1_irq}, 32'h0000_e87c);
    wr(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    wr(`FLAGS_ONE_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0000);
    wr(`FLAGS_ZERO_ADDR, 32'hffff_ffff);
    wr(`FLAGS_ONE_ADDR, 32'hffff_ffff);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_7fef);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_e87f);
    wr(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    wr(`FLAGS_ONE_ADDR, 32'h0000_0000);
  endtask

  task automatic test_precedence();
    u_src.drive_src(16'h0808, 16'h0800);
    wr(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    wr(`FLAGS_ONE_ADDR, 32'h0000_0000);
    u_src.drive_src(16'h0000, 16'h0000);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0808);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0800);
    wr(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    wr(`FLAGS_ONE_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0000);
  endtask

  task automatic test_pins();
    wr(`CTRL_TWO_ADDR, 32'h0000_0002);
    @(posedge pclk);
    chk({29'h0000_0000, ext_irq_edge_polarity}, 32'h0000_0002);
    u_src.set_pins(3'h7);
    repeat (8) @(posedge pclk);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0001);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0002);
    wr(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    wr(`FLAGS_ONE_ADDR, 32'h0000_0000);
    repeat (8) @(posedge pclk);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0000);
    u_src.set_pins(3'h0);
    repeat (8) @(posedge pclk);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0001);
  endtask

  task automatic test_pins_inverted();
    wr(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    wr(`FLAGS_ONE_ADDR, 32'h0000_0000);
    wr(`CTRL_TWO_ADDR, 32'h0000_0005);
    @(posedge pclk);
    chk({29'h0000_0000, ext_irq_edge_polarity}, 32'h0000_0005);
    u_src.set_pins(3'h7);
    repeat (8) @(posedge pclk);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0000);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0001);
    wr(`FLAGS_ONE_ADDR, 32'h0000_0000);
    u_src.set_pins(3'h0);
    repeat (8) @(posedge pclk);
    rd_chk(`FLAGS_ZERO_ADDR, 32'h0000_0001);
    rd_chk(`FLAGS_ONE_ADDR, 32'h0000_0002);
  endtask

  task automatic test_unmapped();
    wr(12'h00c, 32'hffff_ffff);
    chk({31'h0000_0000, serr}, 32'h0000_0001);
    rd_chk(12'h00c, 32'h0000_0000);
    chk({31'h0000_0000, serr}, 32'h0000_0001);
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_ctrl();
    test_flags();
    test_precedence();
    test_pins();
    test_pins_inverted();
    test_unmapped();
    print_verdict();
  end
endmodule
